// ---- core/arith_pkg.sv ----
// Shared types and constants of the binary accumulator arithmetic unit
package arith_pkg;

  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned MEM_AW     = 16;
  localparam int unsigned WORD_W     = 16;

  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_ADDR    = 8'h04;
  localparam logic [7:0] OFF_IMM     = 8'h08;
  localparam logic [7:0] OFF_ACC     = 8'h0c;
  localparam logic [7:0] OFF_STACK1  = 8'h10;
  localparam logic [7:0] OFF_FLAGS   = 8'h14;
  localparam logic [7:0] OFF_INT_ST  = 8'h18;
  localparam logic [7:0] OFF_INT_MSK = 8'h1c;

  // Control register fields
  localparam int unsigned CTRL_OP_LSB  = 0;
  localparam int unsigned CTRL_SRC_LSB = 4;
  localparam int unsigned CTRL_GO_BIT  = 8;
  localparam int unsigned CTRL_BSY_BIT = 9;

  // Interrupt status bits
  localparam int unsigned INT_DONE_BIT  = 0;
  localparam int unsigned INT_RANGE_BIT = 1;
  localparam int unsigned INT_W         = 2;

  // Immediate range limits per instruction
  localparam logic [31:0] IMM_MASK_ADDD = 32'h0fff_ffff;
  localparam logic [31:0] IMM_MASK_D32  = 32'hffff_ffff;
  localparam logic [31:0] IMM_MASK_W16  = 32'h0000_ffff;

  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  localparam logic [4:0]  DIV_STEPS   = 5'h1f;

  typedef enum logic [2:0] {
    OP_ADD_DOUBLE = 3'b000,
    OP_SUB_SINGLE = 3'b001,
    OP_SUB_DOUBLE = 3'b010,
    OP_MUL_SINGLE = 3'b011,
    OP_DIV_SINGLE = 3'b100
  } opcode_t;

  typedef enum logic [1:0] {
    SRC_WORD = 2'b00,
    SRC_PTR  = 2'b01,
    SRC_IMM  = 2'b10
  } src_t;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_FETCH_PTR = 3'b001,
    ST_FETCH_LO  = 3'b010,
    ST_FETCH_HI  = 3'b011,
    ST_EXEC      = 3'b100,
    ST_DIV       = 3'b101
  } fsm_t;

  typedef struct packed {
    logic operand_range_flag;
    logic sign_error_flag;
    logic negative_flag;
    logic carry32_flag;
    logic carry16_flag;
    logic borrow32_flag;
    logic borrow16_flag;
    logic zero_flag;
  } flags_t;

  typedef struct packed {
    logic              req;
    logic [MEM_AW-1:0] addr;
  } mem_req_t;

  typedef struct packed {
    logic              ack;
    logic [WORD_W-1:0] rdata;
  } mem_rsp_t;

endpackage

// ---- core/binary_accumulator_arith.sv ----
// Accumulator binary arithmetic unit with APB registers and operand fetch
//
// Function
// - double add sums 32-bit operand into accumulator, 28-bit when immediate
// - double add operand from two words or immediate
// - single subtract takes 16-bit operand from accumulator
// - double subtract takes 32-bit operand from accumulator
// - multiply 16-bit operand by low 16 bits of accumulator, 32-bit product
// - divide accumulator by 16-bit word, quotient kept
// - divide remainder goes to first stack level
// - divide also accepts 16-bit immediate divisor
// - zero flag set when result is zero
// - negative flag set when result is negative
// - 16-bit carry flag from low half addition
// - 32-bit carry flag from full addition
// - sign error flag on signed overflow of double add
// - 16-bit borrow flag from low half subtraction
// - 32-bit borrow flag from full subtraction
// - divide flags divisor it cannot process
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps

module binary_accumulator_arith (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [arith_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [arith_pkg::DATA_W-1:0]   pwdata,
  output logic      [arith_pkg::DATA_W-1:0]   prdata,
  output logic                                pready,
  output logic                                pslverr,
  output arith_pkg::mem_req_t                 mem_o,
  input  arith_pkg::mem_rsp_t                 mem_i,
  output arith_pkg::flags_t                   flags,
  output logic                                busy,
  output logic                                irq
);
  import arith_pkg::*;

  typedef struct packed {
    fsm_t                  fsm;
    opcode_t               op;
    src_t                  src;
    logic [MEM_AW-1:0]     addr;
    logic [DATA_W-1:0]     imm;
    logic [DATA_W-1:0]     acc;
    logic [DATA_W-1:0]     stack1;
    logic [DATA_W-1:0]     opnd;
    logic [WORD_W:0]       rem;
    logic [4:0]            cnt;
    flags_t                flg;
    logic [INT_W-1:0]      int_st;
    logic [INT_W-1:0]      int_msk;
    mem_req_t              mem;
    logic [DATA_W-1:0]     rdata;
    logic                  ready;
    logic                  slverr;
    logic                  irq;
    logic                  busy;
  } core_st_t;

  core_st_t st_r;
  core_st_t st_nxt;

  // Zero and negative from a 32-bit accumulator result
  function automatic flags_t zn_flags(input flags_t f,
                                      input logic [DATA_W-1:0] v);
    flags_t r;
    r = f;
    r.zero_flag     = (v == RST_WORD);
    r.negative_flag = v[DATA_W-1];
    return r;
  endfunction

  // Operand mask per instruction, so out-of-range constants drop high bits
  function automatic logic [DATA_W-1:0] imm_mask(input opcode_t o);
    logic [DATA_W-1:0] m;
    m = IMM_MASK_W16;
    case (o)
      OP_ADD_DOUBLE: m = IMM_MASK_ADDD;
      OP_SUB_DOUBLE: m = IMM_MASK_D32;
      default:       m = IMM_MASK_W16;
    endcase
    return m;
  endfunction

  function automatic logic is_double(input opcode_t o);
    return (o == OP_ADD_DOUBLE) || (o == OP_SUB_DOUBLE);
  endfunction

  logic              acc_wr;
  logic              rd_done;
  logic [7:0]        reg_off;
  logic [DATA_W:0]   sum33;
  logic [WORD_W:0]   sum17;
  logic [DATA_W:0]   dif33;
  logic [WORD_W:0]   dif17;
  logic [WORD_W:0]   trial;
  logic [INT_W-1:0]  int_set;
  logic [INT_W-1:0]  int_clr;
  logic              go;
  logic [2:0]        wr_op;
  logic [1:0]        wr_src;

  always_comb begin
    st_nxt  = st_r;
    int_set = '0;
    int_clr = '0;
    go      = 1'b0;
    acc_wr  = 1'b0;
    rd_done = 1'b0;
    reg_off = paddr;
    wr_op   = pwdata[CTRL_OP_LSB +: 3];
    wr_src  = pwdata[CTRL_SRC_LSB +: 2];

    sum33 = {1'b0, st_r.acc} + {1'b0, st_r.opnd};
    sum17 = {1'b0, st_r.acc[WORD_W-1:0]} + {1'b0, st_r.opnd[WORD_W-1:0]};
    dif33 = {1'b0, st_r.acc} - {1'b0, st_r.opnd};
    dif17 = {1'b0, st_r.acc[WORD_W-1:0]} - {1'b0, st_r.opnd[WORD_W-1:0]};
    trial = {st_r.rem[WORD_W-1:0], st_r.acc[DATA_W-1]} -
            {1'b0, st_r.opnd[WORD_W-1:0]};

    // APB: one wait state, effects at the edge that samples pready high
    st_nxt.ready  = 1'b0;
    st_nxt.slverr = 1'b0;
    if (psel && penable && !st_r.ready) begin
      st_nxt.ready  = 1'b1;
      st_nxt.rdata  = RST_WORD;
      case (reg_off)
        OFF_CTRL: begin
          st_nxt.rdata[CTRL_OP_LSB +: 3]  = st_r.op;
          st_nxt.rdata[CTRL_SRC_LSB +: 2] = st_r.src;
          st_nxt.rdata[CTRL_BSY_BIT]      = (st_r.fsm != ST_IDLE);
        end
        OFF_ADDR:    st_nxt.rdata[MEM_AW-1:0] = st_r.addr;
        OFF_IMM:     st_nxt.rdata = st_r.imm;
        OFF_ACC:     st_nxt.rdata = st_r.acc;
        OFF_STACK1:  st_nxt.rdata = st_r.stack1;
        OFF_FLAGS:   st_nxt.rdata[7:0] = st_r.flg;
        OFF_INT_ST:  st_nxt.rdata[INT_W-1:0] = st_r.int_st;
        OFF_INT_MSK: st_nxt.rdata[INT_W-1:0] = st_r.int_msk;
        default:     st_nxt.slverr = 1'b1;
      endcase
    end

    if (psel && penable && st_r.ready && !st_r.slverr) begin
      if (pwrite) begin
        case (reg_off)
          OFF_CTRL: begin
            // A start while busy or with an unknown code is dropped
            if (st_r.fsm == ST_IDLE && pwdata[CTRL_GO_BIT] &&
                wr_op <= OP_DIV_SINGLE && wr_src <= SRC_IMM) begin
              st_nxt.op  = opcode_t'(wr_op);
              st_nxt.src = src_t'(wr_src);
              go         = 1'b1;
            end
          end
          OFF_ADDR:    st_nxt.addr    = pwdata[MEM_AW-1:0];
          OFF_IMM:     st_nxt.imm     = pwdata;
          OFF_ACC:     acc_wr         = (st_r.fsm == ST_IDLE);
          OFF_STACK1:  if (st_r.fsm == ST_IDLE) st_nxt.stack1 = pwdata;
          OFF_INT_MSK: st_nxt.int_msk = pwdata[INT_W-1:0];
          default:     ;
        endcase
      end else if (reg_off == OFF_INT_ST) begin
        rd_done = 1'b1;
      end
    end
    if (acc_wr) begin
      st_nxt.acc = pwdata;
    end
    if (rd_done) begin
      int_clr = '1;
    end

    // Operand fetch and execution
    case (st_r.fsm)
      ST_IDLE: begin
        if (go) begin
          st_nxt.opnd = RST_WORD;
          case (st_nxt.src)
            SRC_IMM: begin
              st_nxt.opnd = st_r.imm & imm_mask(st_nxt.op);
              st_nxt.fsm  = ST_EXEC;
            end
            SRC_PTR: begin
              st_nxt.mem.req  = 1'b1;
              st_nxt.mem.addr = st_r.addr;
              st_nxt.fsm      = ST_FETCH_PTR;
            end
            default: begin
              st_nxt.mem.req  = 1'b1;
              st_nxt.mem.addr = st_r.addr;
              st_nxt.fsm      = ST_FETCH_LO;
            end
          endcase
        end
      end
      ST_FETCH_PTR: begin
        // Pointer word holds the operand's word address
        if (mem_i.ack) begin
          st_nxt.mem.addr = mem_i.rdata;
          st_nxt.fsm      = ST_FETCH_LO;
        end
      end
      ST_FETCH_LO: begin
        if (mem_i.ack) begin
          st_nxt.opnd[WORD_W-1:0] = mem_i.rdata;
          if (is_double(st_r.op)) begin
            // Upper word sits in the next consecutive location
            st_nxt.mem.addr = st_r.mem.addr + 16'h0001;
            st_nxt.fsm      = ST_FETCH_HI;
          end else begin
            st_nxt.mem.req = 1'b0;
            st_nxt.fsm     = ST_EXEC;
          end
        end
      end
      ST_FETCH_HI: begin
        if (mem_i.ack) begin
          st_nxt.opnd[DATA_W-1:WORD_W] = mem_i.rdata;
          st_nxt.mem.req               = 1'b0;
          st_nxt.fsm                   = ST_EXEC;
        end
      end
      ST_EXEC: begin
        st_nxt.fsm = ST_IDLE;
        int_set[INT_DONE_BIT] = 1'b1;
        case (st_r.op)
          OP_ADD_DOUBLE: begin
            st_nxt.acc = sum33[DATA_W-1:0];
            st_nxt.flg = zn_flags(st_r.flg, sum33[DATA_W-1:0]);
            st_nxt.flg.carry16_flag = sum17[WORD_W];
            st_nxt.flg.carry32_flag = sum33[DATA_W];
            st_nxt.flg.sign_error_flag =
              (st_r.acc[DATA_W-1] == st_r.opnd[DATA_W-1]) &&
              (sum33[DATA_W-1] != st_r.acc[DATA_W-1]);
          end
          OP_SUB_SINGLE, OP_SUB_DOUBLE: begin
            // Single form fetched one word, so the upper half is zero
            st_nxt.acc = dif33[DATA_W-1:0];
            st_nxt.flg = zn_flags(st_r.flg, dif33[DATA_W-1:0]);
            st_nxt.flg.borrow16_flag = dif17[WORD_W];
            st_nxt.flg.borrow32_flag = dif33[DATA_W];
          end
          OP_MUL_SINGLE: begin
            st_nxt.acc = st_r.acc[WORD_W-1:0] *
                         st_r.opnd[WORD_W-1:0];
            st_nxt.flg = zn_flags(st_r.flg,
                         st_r.acc[WORD_W-1:0] *
                         st_r.opnd[WORD_W-1:0]);
          end
          default: begin
            // A zero divisor cannot be processed: accumulator left alone
            if (st_r.opnd[WORD_W-1:0] == 16'h0000) begin
              st_nxt.flg.operand_range_flag = 1'b1;
              int_set[INT_RANGE_BIT]        = 1'b1;
            end else begin
              st_nxt.flg.operand_range_flag = 1'b0;
              int_set[INT_DONE_BIT] = 1'b0;
              st_nxt.rem = '0;
              st_nxt.cnt = DIV_STEPS;
              st_nxt.fsm = ST_DIV;
            end
          end
        endcase
      end
      ST_DIV: begin
        // Restoring divide, one quotient bit per cycle shifted into acc
        if (!trial[WORD_W]) begin
          st_nxt.rem = trial;
          st_nxt.acc = {st_r.acc[DATA_W-2:0], 1'b1};
        end else begin
          st_nxt.rem = {st_r.rem[WORD_W-1:0], st_r.acc[DATA_W-1]};
          st_nxt.acc = {st_r.acc[DATA_W-2:0], 1'b0};
        end
        st_nxt.cnt = st_r.cnt - 5'h01;
        if (st_r.cnt == 5'h00) begin
          st_nxt.stack1 = {16'h0000, st_nxt.rem[WORD_W-1:0]};
          st_nxt.flg    = zn_flags(st_r.flg, st_nxt.acc);
          st_nxt.fsm    = ST_IDLE;
          int_set[INT_DONE_BIT] = 1'b1;
        end
      end
      default: st_nxt.fsm = ST_IDLE;
    endcase

    // Set beats a read clear in the same cycle
    st_nxt.int_st = (st_r.int_st & ~int_clr) | int_set;
    st_nxt.irq    = |(st_nxt.int_st & st_nxt.int_msk);
    // Registered so the pin carries no decode glitches
    st_nxt.busy   = (st_nxt.fsm != ST_IDLE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata  = st_r.rdata;
  assign pready  = st_r.ready;
  assign pslverr = st_r.slverr;
  assign mem_o   = st_r.mem;
  assign flags   = st_r.flg;
  assign busy    = st_r.busy;
  assign irq     = st_r.irq;

endmodule

// ---- tb/arith_mem_model.sv ----
// Operand memory model answering the unit's fetch requests
`timescale 1ns/10ps
module arith_mem_model (
  input  wire logic          pclk,
  input  wire logic [3:0]    dly,
  input  arith_pkg::mem_req_t mem_o,
  output arith_pkg::mem_rsp_t mem_i
);
  import arith_pkg::*;
  int cnt = 0;
  initial mem_i = '0;
  // Each word holds its address inverted, so results are predictable
  always @(posedge pclk) begin
    mem_i.ack <= 1'b0;
    // Unanswered data keeps toggling, so stale words never look valid
    mem_i.rdata <= ~mem_i.rdata;
    if (mem_o.req && !mem_i.ack && cnt >= dly) begin
      mem_i.ack   <= 1'b1;
      mem_i.rdata <= ~mem_o.addr;
      cnt         <= 0;
    end else if (mem_o.req) begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ---- tb/binary_accumulator_arith_assertions.sv ----
// Port assertions for the accumulator arithmetic unit
`timescale 1ns/10ps
module binary_accumulator_arith_assertions (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire arith_pkg::mem_req_t mem_o,
  input wire arith_pkg::mem_rsp_t mem_i,
  input wire arith_pkg::flags_t   flags,
  input wire logic                busy,
  input wire logic                irq
);
  import arith_pkg::*;
  logic       xfer, rd_acc, go;
  logic [2:0] op_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign xfer   = psel && penable && pready;
  assign rd_acc = xfer && !pwrite && paddr == OFF_ACC && !busy;
  assign go     = xfer && pwrite && paddr == OFF_CTRL && !busy
                  && pwdata[CTRL_GO_BIT];
  // The ports do not show the running operation, so keep it here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) op_r <= 3'h0;
    else if (go) op_r <= pwdata[2:0];
  end
  property p_zero; rd_acc |-> flags.zero_flag == (prdata == 32'h0);
  endproperty
  property p_neg; rd_acc |-> flags.negative_flag == prdata[31]; endproperty
  property p_hold; !busy && !$past(busy) |-> $stable(flags); endproperty
  property p_add; $fell(busy) && op_r == OP_ADD_DOUBLE
    |-> $stable(flags[7]) && $stable(flags[2:1]); endproperty
  property p_sub; $fell(busy) && (op_r == OP_SUB_SINGLE
    || op_r == OP_SUB_DOUBLE) |-> $stable(flags[7:6]) && $stable(flags[4:3]);
  endproperty
  property p_mul; $fell(busy) && op_r == OP_MUL_SINGLE
    |-> $stable(flags[7:6]) && $stable(flags[4:1]); endproperty
  property p_div; $fell(busy) && op_r == OP_DIV_SINGLE
    |-> $stable(flags[6]) && $stable(flags[4:1]); endproperty
  property p_start; go |=> busy; endproperty
  // A zero divisor ends after one cycle, so only real divides count
  property p_div_run; $fell(busy) && op_r == OP_DIV_SINGLE
    && !flags.operand_range_flag |-> $past(busy, 8); endproperty
  property p_addr; mem_o.req && !mem_i.ack |=> $stable(mem_o.addr);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  a_neg: assert property (p_neg) else $error("negative flag wrong");
  a_hold: assert property (p_hold) else $error("flags moved idle");
  a_add: assert property (p_add) else $error("add touched flags");
  a_sub: assert property (p_sub) else $error("sub touched flags");
  a_mul: assert property (p_mul) else $error("mul touched flags");
  a_div: assert property (p_div) else $error("div touched flags");
  a_start: assert property (p_start) else $error("no start");
  a_div_run: assert property (p_div_run) else $error("div short");
  a_addr: assert property (p_addr) else $error("addr moved");
  c_range: cover property ($rose(flags.operand_range_flag));
  c_irq: cover property ($rose(irq));
  c_fetch: cover property (mem_o.req && mem_i.ack ##1 mem_o.req);
endmodule
bind binary_accumulator_arith binary_accumulator_arith_assertions i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .mem_o(mem_o), .mem_i(mem_i),
  .flags(flags), .busy(busy), .irq(irq));

// ---- tb/binary_accumulator_arith_tb.sv ----
// Self-checking bench for the accumulator arithmetic unit
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) begin \
      fails++; \
      $display("ERROR %s exp %0h got %0h", nm, e, g); \
    end \
  end
module binary_accumulator_arith_tb;
  import arith_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        busy, irq, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, acc, flg;
  logic [3:0]  dly;
  mem_req_t    mem_o;
  mem_rsp_t    mem_i;
  flags_t      flags;
  int          fails = 0;
  int          num_checks = 0;
  binary_accumulator_arith i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_o(mem_o), .mem_i(mem_i),
    .flags(flags), .busy(busy), .irq(irq));
  arith_mem_model i_mem (
    .pclk(pclk), .dly(dly), .mem_o(mem_o), .mem_i(mem_i));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) fails++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic [2:0] o, input logic [1:0] s,
                     input logic [15:0] a, input logic [31:0] im, a0);
    int n = 0;
    apb(1'b1, OFF_ACC, a0);
    apb(1'b1, OFF_ADDR, {16'h0, a});
    apb(1'b1, OFF_IMM, im);
    apb(1'b1, OFF_CTRL, {23'h0, 1'b1, 2'h0, s, 1'b0, o});
    @(posedge pclk);
    while (busy !== 1'b0 && ++n < 100) @(posedge pclk);
    if (n >= 100) fails++;
    apb(1'b0, OFF_ACC, 32'h0);
    acc = q;
    // Flags are taken before the next instruction can overwrite them
    apb(1'b0, OFF_FLAGS, 32'h0);
    flg = q;
  endtask
  task automatic t_add;
    run(OP_ADD_DOUBLE, SRC_IMM, 16'h0, 32'hf000_0001, 32'h7fff_ffff);
    `CHK("add imm", 32'h7fff_ffff + (32'hf000_0001 & IMM_MASK_ADDD), acc)
    `CHK("sign err", 1'b1, flg[6])
    `CHK("c16", 1'b1, flg[3])
    `CHK("neg", 1'b1, flg[5])
    `CHK("flags pin", 8'h68, flags)
    run(OP_ADD_DOUBLE, SRC_WORD, 16'h0010, 32'h0, 32'h0011_0011);
    `CHK("add word", 32'h0011_0011 + {~16'h0011, ~16'h0010}, acc)
    `CHK("c32", 1'b1, flg[4])
    `CHK("zero", 1'b1, flg[0])
    $display("test add done");
  endtask
  task automatic t_sub;
    @(posedge pclk) dly <= 4'h3;
    // Pointer word is ~1, whose own word brings the operand back to 1
    run(OP_SUB_SINGLE, SRC_PTR, 16'h0001, 32'h0, 32'h0001_0000);
    `CHK("sub ptr", 32'h0001_0000 - 32'h1, acc)
    `CHK("b32 b16", 2'b01, flg[2:1])
    run(OP_SUB_SINGLE, SRC_IMM, 16'h0, 32'h0001_0002, 32'h2);
    `CHK("sub zero", 1'b1, flg[0])
    run(OP_SUB_DOUBLE, SRC_IMM, 16'h0, 32'h6, 32'h5);
    `CHK("sub dbl", 32'h5 - 32'h6, acc)
    `CHK("b32 b16", 2'b11, flg[2:1])
    @(posedge pclk) dly <= 4'h0;
    $display("test sub done");
  endtask
  task automatic t_mul;
    run(OP_MUL_SINGLE, SRC_IMM, 16'h0, 32'h0001_ffff, 32'h1234_ffff);
    `CHK("mul", 32'hffff * (32'h0001_ffff & IMM_MASK_W16), acc)
    run(OP_MUL_SINGLE, SRC_WORD, 16'hffff, 32'h0, 32'h7);
    `CHK("mul zero", 2'b01, {flg[5], flg[0]})
    $display("test mul done");
  endtask
  task automatic t_div;
    apb(1'b1, OFF_INT_MSK, 32'h2);
    run(OP_DIV_SINGLE, SRC_WORD, 16'h0, 32'h0, 32'h0003_0004);
    `CHK("quot", 32'h0003_0004 / 32'hffff, acc)
    apb(1'b0, OFF_STACK1, 32'h0);
    `CHK("rem", 32'h0003_0004 % 32'hffff, q)
    `CHK("irq masked", 1'b0, irq)
    run(OP_DIV_SINGLE, SRC_IMM, 16'h0, 32'h0, 32'h9);
    `CHK("range acc", 2'b11, {flg[7], acc == 32'h9})
    `CHK("irq", 1'b1, irq)
    apb(1'b0, OFF_INT_ST, 32'h0);
    `CHK("status", 2'b11, q[1:0])
    repeat (2) @(posedge pclk);
    `CHK("irq clr", 1'b0, irq)
    run(OP_DIV_SINGLE, SRC_IMM, 16'h0, 32'h0001_0003, 32'h7);
    `CHK("imm div", {1'b0, 32'h7 / 32'h3}, {flg[7], acc})
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {err, q})
    $display("test div done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn, dly} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_add;
    t_sub;
    t_mul;
    t_div;
    summarize;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    fails++;
    summarize;
  end
endmodule
